// [rtl/bsnl_decoder.sv]
// Decoder and executor for the bank select register nibble loads
// Function
// [RL1] Upper nibble load decodes by prefix 1011 101x, literal in bits 7:4.
// [RL2] Upper nibble load copies its 4-bit literal into bank bits 7:4.
// [RL3] Upper nibble load keeps bank bits 3:0 and touches no status flags.
// [RL4] Reduced variant build omits the upper nibble load decode entirely.
// [RL5] Lower nibble load writes only bank bits 3:0, upper half kept.
// [RL6] Either load takes one cycle: decode, read, execute, write in Q1..Q4.
`timescale 1ns/1ps

module bsnl_decoder
  import bsnl_pkg::*;
#(
  parameter bit HAS_HIGH_LOAD = 1'b1
)
(
  input  wire logic           mclk,
  input  wire logic           arst_n,
  input  wire bsnl_instr_type instr,
  output logic                q1_strobe,
  output logic [7:0]          bank_select_reg,
  output logic                load_done
);

  // ----------------------------------------------------------------
  // Q phase sequencer
  // ----------------------------------------------------------------
  bsnl_phase_type phase_q;
  bsnl_phase_type phase_d;

  // Free running four-phase instruction cycle
  always_comb
  begin
    case (phase_q)
      BSNL_Q1: phase_d = BSNL_Q2;
      BSNL_Q2: phase_d = BSNL_Q3;
      BSNL_Q3: phase_d = BSNL_Q4;
      BSNL_Q4: phase_d = BSNL_Q1;
      default: phase_d = BSNL_Q1;
    endcase
  end

  // Reset parks the sequencer in Q1 so the first edge after release decodes
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      phase_q <= BSNL_Q1;
    else
      phase_q <= phase_d;
  end

  // Tells the fetch side which edge takes the next word
  assign q1_strobe = (phase_q == BSNL_Q1);

  // ----------------------------------------------------------------
  // Decode in Q1
  // ----------------------------------------------------------------
  // Word and decode are held for the rest of the instruction cycle
  logic [15:0] instr_q;
  logic        is_high_q;
  logic        is_low_q;
  logic [3:0]  lit_q;
  logic [3:0]  lit_d;
  wire         dec_high;
  wire         dec_low;

  // Low bit of the high prefix is don't care; literal bits of the low field
  // are never looked at so a nonzero u field still decodes.
  assign dec_high = HAS_HIGH_LOAD && instr.valid
                    && (instr.word[15:9] == BSNL_OP_HIGH_PFX);  // RL1 RL4
  assign dec_low  = instr.valid && (instr.word[15:8] == BSNL_OP_LOW_PFX);

  // Capture the word and its decode at Q1 only
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      instr_q   <= BSNL_INSTR_RST;
      is_high_q <= 1'b0;
      is_low_q  <= 1'b0;
    end
    else if (phase_q == BSNL_Q1)
    begin
      instr_q   <= instr.word;
      is_high_q <= dec_high;  // RL6
      is_low_q  <= dec_low;
    end
  end

  // ----------------------------------------------------------------
  // Literal read in Q2
  // ----------------------------------------------------------------
  assign lit_d = is_high_q ? instr_q[BSNL_K_HIGH_MSB:BSNL_K_HIGH_LSB]   // RL1
                           : instr_q[BSNL_K_LOW_MSB:BSNL_K_LOW_LSB];

  // Literal latched once per cycle, in Q2 only
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      lit_q <= 4'h0;
    else if (phase_q == BSNL_Q2)
      lit_q <= lit_d;  // RL6
  end

  // ----------------------------------------------------------------
  // Execute in Q3, write in Q4
  // ----------------------------------------------------------------
  // Staged merge result, so the visible register moves only at Q4
  logic [7:0] bank_q;
  logic [7:0] bank_exec_q;
  logic [7:0] bank_exec_d;
  logic       done_q;

  // Merge chooses the nibble; the other half always comes from the register
  assign bank_exec_d = is_high_q ? {lit_q, bank_q[3:0]}   // RL2 RL3
                     : is_low_q  ? {bank_q[7:4], lit_q}   // RL5
                     : bank_q;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      bank_exec_q <= BSNL_BANK_RST;
    else if (phase_q == BSNL_Q3)
      bank_exec_q <= bank_exec_d;
  end

  // Commit at Q4 end; no status flags exist here to be disturbed
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bank_q <= BSNL_BANK_RST;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= (phase_q == BSNL_Q4) && (is_high_q || is_low_q);
      if (phase_q == BSNL_Q4)
        bank_q <= bank_exec_q;  // RL6 RL3
    end
  end

  // Both outputs come straight from flops
  assign bank_select_reg = bank_q;
  assign load_done       = done_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // The release edge still samples the parked Q1 phase; an idle word there
  // keeps the take-anchored checks true, so no extra mask is needed
  // Upper load: literal lands in 7:4 while 3:0 keeps its old value
  property p_high_load;
    @(posedge mclk) disable iff (!arst_n)
      (q1_strobe && instr.valid && instr.word[15:9] == BSNL_OP_HIGH_PFX && HAS_HIGH_LOAD)
      |-> ##4 (bank_select_reg[7:4] == $past(instr.word[7:4], 4))
              && (bank_select_reg[3:0] == $past(bank_select_reg[3:0], 4));
  endproperty
  a_high_load: assert property (p_high_load) else $error("high nibble load wrong");  // RL2

  // Lower load: literal lands in 3:0 and the upper half is carried over
  property p_low_load;
    @(posedge mclk) disable iff (!arst_n)
      (q1_strobe && instr.valid && instr.word[15:8] == BSNL_OP_LOW_PFX)
      |-> ##4 (bank_select_reg == {$past(bank_select_reg[7:4], 4), $past(instr.word[3:0], 4)});
  endproperty
  a_low_load: assert property (p_low_load) else $error("low nibble load wrong");  // RL5

  // Reduced build must never even latch an upper nibble decode
  property p_no_variant;
    @(posedge mclk) disable iff (!arst_n)
      !HAS_HIGH_LOAD |-> !is_high_q;
  endproperty
  a_no_variant: assert property (p_no_variant) else $error("high load decoded on reduced build");  // RL4

  // Bank only moves at the Q4 commit, seen at the following Q1 sample
  property p_stable_mid;
    @(posedge mclk) disable iff (!arst_n)
      !(phase_q == BSNL_Q1) |-> $stable(bank_select_reg);
  endproperty
  a_stable_mid: assert property (p_stable_mid) else $error("bank changed outside Q4 write");  // RL6

  // Completion is a single pulse lined up with Q1
  property p_done_pulse;
    @(posedge mclk) disable iff (!arst_n)
      load_done |-> q1_strobe ##1 !load_done [*3];
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not once per cycle");  // RL6

  // Anything but an accepted load leaves the bank alone; on the reduced
  // build this covers the refused upper nibble load as well
  property p_other_op;
    @(posedge mclk) disable iff (!arst_n)
      (q1_strobe && !(instr.valid && ((HAS_HIGH_LOAD && instr.word[15:9] == BSNL_OP_HIGH_PFX)
                                      || instr.word[15:8] == BSNL_OP_LOW_PFX)))
      |-> ##4 $stable(bank_select_reg);
  endproperty
  a_other_op: assert property (p_other_op) else $error("bank changed by other opcode");  // RL1 RL4

  // Q1 returns every fourth edge once the sequencer has left it
  property p_q1_cadence;
    @(posedge mclk) disable iff (!arst_n)
      (q1_strobe ##1 !q1_strobe) |-> ##1 !q1_strobe [*2] ##1 q1_strobe;
  endproperty
  a_q1_cadence: assert property (p_q1_cadence) else $error("Q1 phase cadence broken");  // RL6

  // An accepted load flags completion in the cycle after its Q4 commit
  property p_done_on_load;
    @(posedge mclk) disable iff (!arst_n)
      (q1_strobe && instr.valid && ((HAS_HIGH_LOAD && instr.word[15:9] == BSNL_OP_HIGH_PFX)
                                    || instr.word[15:8] == BSNL_OP_LOW_PFX))
      |-> ##4 load_done;
  endproperty
  a_done_on_load: assert property (p_done_on_load) else $error("load finished without done");  // RL6

  // Refused or foreign words never raise the completion flag
  property p_no_done_other;
    @(posedge mclk) disable iff (!arst_n)
      (q1_strobe && !(instr.valid && ((HAS_HIGH_LOAD && instr.word[15:9] == BSNL_OP_HIGH_PFX)
                                      || instr.word[15:8] == BSNL_OP_LOW_PFX)))
      |-> ##4 !load_done;
  endproperty
  a_no_done_other: assert property (p_no_done_other) else $error("done raised without a load");  // RL4

endmodule

// [rtl/bsnl_pkg.sv]
// Package: constants and types for the bank select nibble load decoder
package bsnl_pkg;

  // ----------------------------------------------------------------
  // Opcode fields
  // ----------------------------------------------------------------
  localparam logic [6:0] BSNL_OP_HIGH_PFX = 7'h5D;  // 1011 101x, upper 7 bits
  localparam logic [7:0] BSNL_OP_LOW_PFX  = 8'hB8;  // 1011 1000
  localparam int         BSNL_K_HIGH_MSB  = 7;      // High load literal field
  localparam int         BSNL_K_HIGH_LSB  = 4;
  localparam int         BSNL_K_LOW_MSB   = 3;      // Low load literal field
  localparam int         BSNL_K_LOW_LSB   = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  BSNL_BANK_RST  = 8'h00;
  localparam logic [15:0] BSNL_INSTR_RST = 16'h0000;

  // Q phase sequencer, Gray coded along Q1..Q4
  typedef enum logic [1:0]
  {
    BSNL_Q1 = 2'b00,
    BSNL_Q2 = 2'b01,
    BSNL_Q3 = 2'b11,
    BSNL_Q4 = 2'b10
  } bsnl_phase_type;

  // Fetched instruction word with its valid strobe
  typedef struct packed
  {
    logic        valid;
    logic [15:0] word;
  } bsnl_instr_type;

endpackage

// [sim/bank_select_nibble_load_bench.sv]
// Self-checking bench for the bank select nibble load decoder
`timescale 1ns/1ps

module bank_select_nibble_load_bench;
  import bsnl_pkg::*;

  logic           mclk = 1'b0;
  logic           arst_n = 1'b0;
  bsnl_instr_type instr = '0;
  logic           q1, done, q1_r, done_r;
  logic [7:0]     bank, bank_r;
  int             errors = 0;
  int             num_checks = 0;
  // Rows: valid, word, full bank, reduced bank, full done, reduced done; each row sees the last
  logic [34:0]    rows [11] = '{
    {1'b1, 16'hB802, 8'h02, 8'h02, 1'b1, 1'b1}, {1'b1, 16'hBA20, 8'h22, 8'h02, 1'b1, 1'b0},
    {1'b1, 16'hBA50, 8'h52, 8'h02, 1'b1, 1'b0}, {1'b1, 16'hBB90, 8'h92, 8'h02, 1'b1, 1'b0},
    {1'b1, 16'hB80F, 8'h9F, 8'h0F, 1'b1, 1'b1}, {1'b1, 16'hBAF7, 8'hFF, 8'h0F, 1'b1, 1'b0},
    {1'b1, 16'hB900, 8'hFF, 8'h0F, 1'b0, 1'b0}, {1'b1, 16'hBC30, 8'hFF, 8'h0F, 1'b0, 1'b0},
    {1'b1, 16'hB0A5, 8'hFF, 8'h0F, 1'b0, 1'b0}, {1'b0, 16'hB801, 8'hFF, 8'h0F, 1'b0, 1'b0},
    {1'b1, 16'hB8A3, 8'hF3, 8'h03, 1'b1, 1'b1}};

  always #2.5 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Full build and reduced build share one instruction stream
  // ----------------------------------------------------------------
  bsnl_decoder i_dut (.mclk(mclk), .arst_n(arst_n), .instr(instr), .q1_strobe(q1),
    .bank_select_reg(bank), .load_done(done));
  bsnl_decoder #(.HAS_HIGH_LOAD(1'b0)) i_dut_red (.mclk(mclk), .arst_n(arst_n), .instr(instr),
    .q1_strobe(q1_r), .bank_select_reg(bank_r), .load_done(done_r));

  // Byte results: bank select register of either build
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e)
    begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask

  // Single-bit results: phase strobe and completion pulse
  task automatic chk_flag(input string n, input logic e, input logic s);
    num_checks++;
    if (s !== e)
    begin
      errors++;
      $display("CHECK FAILED %s exp %b got %b", n, e, s);
    end
  endtask

  // Issue at a Q1 edge; check lands 1 ns after the Q4 edge so the next op can start there
  task automatic op(input logic [34:0] r);
    instr <= '{r[34], r[33:18]};
    @(posedge mclk);
    instr.valid <= 1'b0;
    repeat (3) @(posedge mclk);
    fork
      begin
        #1;
        chk("bank", r[17:10], bank);
        chk("bank_red", r[9:2], bank_r);
        chk_flag("done", r[1], done);
        chk_flag("done_red", r[0], done_r);
        chk_flag("q1", 1'b1, q1);
        chk_flag("q1_red", 1'b1, q1_r);
      end
    join_none
  endtask

  task summarize;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Main sequence: reset, table, then a reset in mid-run
  initial
  begin
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    foreach (rows[i])
      op(rows[i]);
    @(posedge mclk);
    arst_n <= 1'b0;
    @(posedge mclk);
    #1;
    chk("rst_bank", 8'h00, bank);
    chk("rst_bank_red", 8'h00, bank_r);
    chk_flag("rst_q1", 1'b1, q1);
    chk_flag("rst_done", 1'b0, done);
    @(posedge mclk);
    arst_n <= 1'b1;
    op({1'b1, 16'hBA70, 8'h70, 8'h00, 1'b1, 1'b0});
    repeat (2) @(posedge mclk);
    summarize;
  end

  // Run needs about 73 cycles; a hang is cut short well past that
  initial
  begin
    #2000;
    errors++;
    summarize;
  end
endmodule
